// ---- rtl/pmc_map.vh ----
// Constants for the power mode controller
// Contract
// - Sleep halts CPU, oscillators and peripherals run
// - Enabled unmasked interrupt ends sleep
// - Sleep returns to active of same speed
// - Interrupt reaches exception start within two clocks
// - Reset pin low ends sleep, resets CPU
// - Standby stops main oscillator, ports high impedance
// - Standby wake restarts oscillator, waits, then exception
// - Standby exit speed from medium speed select
// - Watch keeps only timekeeping peripherals, ports hold
// - Watch wake goes active or subactive per bits
// - Subsleep wakes into subactive mode
// - Subactive stops main oscillator; sleep decodes bits
// - Subactive CPU clock is watch clock /2/4/8
// - Medium speed sleep decodes standby, watch, sleep, direct
// - Medium speed peripherals use divider field
// - Direct switch enable switches without halting program
// - Direct interrupt disabled falls back to sleep/watch
// - Direct via sleep to active speed per select
// - Direct from active via watch to subactive
// - Direct from subactive via watch, wait, active
// - Active sleep with stop bits enters standby
`ifndef PMC_MAP_VH
`define PMC_MAP_VH
`define PMC_ST_ACT_HI 9'h001
`define PMC_ST_ACT_MED 9'h002
`define PMC_ST_SLEEP_HI 9'h004
`define PMC_ST_SLEEP_MED 9'h008
`define PMC_ST_STANDBY 9'h010
`define PMC_ST_WATCH 9'h020
`define PMC_ST_SUBACT 9'h040
`define PMC_ST_SUBSLEEP 9'h080
`define PMC_ST_WAKE_WAIT 9'h100
`define PMC_SA_DIV2 2'h0
`define PMC_SA_DIV4 2'h1
`define PMC_WAIT_W 14
`define PMC_WAIT_0 14'h2000
`define PMC_WAIT_1 14'h3fff
`define PMC_WAIT_2 14'h0800
`define PMC_WAIT_3 14'h0400
`define PMC_WAIT_4 14'h0100
`define PMC_WAIT_5 14'h0040
`define PMC_WAIT_6 14'h0020
`define PMC_WAIT_7 14'h0010
`endif

// ---- rtl/pmc_wake_timer.v ----
// Oscillator settling wait counter for the power mode controller
`timescale 1ns/10ps
`include "pmc_map.vh"
module pmc_wake_timer #(
    parameter W = `PMC_WAIT_W
) (
    clk,
    sys_rst,
    start,
    wake_wait_sel,
    done
);
    input wire clk;
    input wire sys_rst;
    input wire start;
    input wire [2:0] wake_wait_sel;
    output wire done;
    reg [W-1:0] cnt_r;
    reg run_r;
    reg [W-1:0] load;
    always @* begin
        case (wake_wait_sel)
            3'h0: load = `PMC_WAIT_0;
            3'h1: load = `PMC_WAIT_1;
            3'h2: load = `PMC_WAIT_2;
            3'h3: load = `PMC_WAIT_3;
            3'h4: load = `PMC_WAIT_4;
            3'h5: load = `PMC_WAIT_5;
            3'h6: load = `PMC_WAIT_6;
            default: load = `PMC_WAIT_7;
        endcase
    end
    // Done pulses when the count reaches one after a start
    assign done = run_r && (cnt_r == {{(W-1){1'b0}}, 1'b1});
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= {W{1'b0}};
            run_r <= 1'b0;
        end else if (start) begin
            cnt_r <= load;
            run_r <= 1'b1;
        end else if (run_r) begin
            cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
            if (done) begin
                run_r <= 1'b0;
            end
        end
    end
endmodule

// ---- rtl/pmc_ctrl.v ----
// Power mode sequencer: sleep, standby, watch, subsleep, subactive, active
`timescale 1ns/10ps
`include "pmc_map.vh"
module pmc_ctrl #(
    parameter WAIT_W = `PMC_WAIT_W
) (
    clk,
    sys_rst,
    external_reset_pin_n,
    sleep_exec,
    irq_pending,
    irq_enabled,
    int_mask,
    direct_irq_enable,
    deep_stop_select,
    low_speed_select,
    watch_timer_select,
    medium_speed_select,
    direct_switch_enable,
    periph_div_sel_hi,
    periph_div_sel_lo,
    subactive_freq_hi,
    subactive_freq_lo,
    wake_wait_sel_2,
    wake_wait_sel_1,
    wake_wait_sel_0,
    cpu_reset,
    cpu_halt,
    cpu_run,
    main_osc_en,
    sub_osc_en,
    periph_clk_en,
    periph_div,
    timekeep_clk_en,
    adc_pwm_clk_en,
    ports_hiz,
    ports_hold,
    cpu_on_subclock,
    cpu_sub_div,
    exc_start,
    exc_direct,
    mode
);
    input wire clk;
    input wire sys_rst;
    input wire external_reset_pin_n;
    input wire sleep_exec;
    input wire irq_pending;
    input wire irq_enabled;
    input wire int_mask;
    input wire direct_irq_enable;
    input wire deep_stop_select;
    input wire low_speed_select;
    input wire watch_timer_select;
    input wire medium_speed_select;
    input wire direct_switch_enable;
    input wire periph_div_sel_hi;
    input wire periph_div_sel_lo;
    input wire subactive_freq_hi;
    input wire subactive_freq_lo;
    input wire wake_wait_sel_2;
    input wire wake_wait_sel_1;
    input wire wake_wait_sel_0;
    output reg cpu_reset;
    output wire cpu_halt;
    output wire cpu_run;
    output reg main_osc_en;
    output reg sub_osc_en;
    output reg periph_clk_en;
    output reg [1:0] periph_div;
    output reg timekeep_clk_en;
    output reg adc_pwm_clk_en;
    output reg ports_hiz;
    output reg ports_hold;
    output reg cpu_on_subclock;
    output reg [3:0] cpu_sub_div;
    output reg exc_start;
    output reg exc_direct;
    output wire [8:0] mode;

    reg [8:0] state_r;
    reg [8:0] state_nxt;
    reg wait_med_r;
    reg wait_med_nxt;
    reg pend_direct_r;
    reg pend_direct_nxt;
    reg irq_sync_r;
    reg exc_nxt;
    reg exc_dir_nxt;
    reg timer_start;
    wire timer_done;
    wire [8:0] mode_nxt;
    wire wake_ok;
    wire dt_ok;

    pmc_wake_timer #(.W(WAIT_W)) u_wait (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(timer_start),
        .wake_wait_sel({wake_wait_sel_2, wake_wait_sel_1, wake_wait_sel_0}),
        .done(timer_done)
    );

    // One register stage keeps request to exception start within two clocks
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_sync_r <= 1'b0;
        end else begin
            irq_sync_r <= irq_pending && irq_enabled && !int_mask;
        end
    end
    assign wake_ok = irq_sync_r;
    // Masked direct request would strand the part in sleep or watch
    assign dt_ok = direct_switch_enable && direct_irq_enable;

    always @* begin
        state_nxt = state_r;
        wait_med_nxt = wait_med_r;
        pend_direct_nxt = pend_direct_r;
        exc_nxt = 1'b0;
        exc_dir_nxt = 1'b0;
        timer_start = 1'b0;
        case (state_r)
            `PMC_ST_ACT_HI, `PMC_ST_ACT_MED: begin
                if (sleep_exec) begin
                    if (!deep_stop_select) begin
                        if (dt_ok && !low_speed_select) begin
                            // Pass through sleep, then land at new speed
                            state_nxt = medium_speed_select ? `PMC_ST_SLEEP_MED :
                                `PMC_ST_SLEEP_HI;
                            pend_direct_nxt = 1'b1;
                        end else begin
                            state_nxt = (state_r == `PMC_ST_ACT_MED) ? `PMC_ST_SLEEP_MED :
                                `PMC_ST_SLEEP_HI;
                        end
                    end else if (watch_timer_select && low_speed_select && dt_ok) begin
                        state_nxt = `PMC_ST_WATCH;
                        pend_direct_nxt = 1'b1;
                    end else if (watch_timer_select && !low_speed_select) begin
                        state_nxt = `PMC_ST_STANDBY;
                    end else begin
                        state_nxt = `PMC_ST_WATCH;
                    end
                end
            end
            `PMC_ST_SLEEP_HI, `PMC_ST_SLEEP_MED: begin
                if (pend_direct_r) begin
                    // Direct switch resumes at once with its own exception
                    state_nxt = (state_r == `PMC_ST_SLEEP_MED) ? `PMC_ST_ACT_MED :
                        `PMC_ST_ACT_HI;
                    pend_direct_nxt = 1'b0;
                    exc_nxt = 1'b1;
                    exc_dir_nxt = 1'b1;
                end else if (wake_ok) begin
                    state_nxt = (state_r == `PMC_ST_SLEEP_MED) ? `PMC_ST_ACT_MED :
                        `PMC_ST_ACT_HI;
                    exc_nxt = 1'b1;
                end
            end
            `PMC_ST_STANDBY: begin
                if (wake_ok) begin
                    timer_start = 1'b1;
                    wait_med_nxt = medium_speed_select;
                    state_nxt = `PMC_ST_WAKE_WAIT;
                end
            end
            `PMC_ST_WATCH: begin
                if (pend_direct_r) begin
                    if (low_speed_select) begin
                        pend_direct_nxt = 1'b0;
                        state_nxt = `PMC_ST_SUBACT;
                        exc_nxt = 1'b1;
                        exc_dir_nxt = 1'b1;
                    end else begin
                        // Direct flag rides through the wait so the exit is marked direct
                        timer_start = 1'b1;
                        wait_med_nxt = medium_speed_select;
                        state_nxt = `PMC_ST_WAKE_WAIT;
                    end
                end else if (wake_ok) begin
                    if (low_speed_select) begin
                        state_nxt = `PMC_ST_SUBACT;
                        exc_nxt = 1'b1;
                    end else begin
                        timer_start = 1'b1;
                        wait_med_nxt = medium_speed_select;
                        state_nxt = `PMC_ST_WAKE_WAIT;
                    end
                end
            end
            `PMC_ST_WAKE_WAIT: begin
                if (timer_done) begin
                    state_nxt = wait_med_r ? `PMC_ST_ACT_MED : `PMC_ST_ACT_HI;
                    exc_nxt = 1'b1;
                    exc_dir_nxt = pend_direct_r;
                    pend_direct_nxt = 1'b0;
                end
            end
            `PMC_ST_SUBACT: begin
                if (sleep_exec) begin
                    if (deep_stop_select && watch_timer_select && !low_speed_select &&
                            dt_ok) begin
                        state_nxt = `PMC_ST_WATCH;
                        pend_direct_nxt = 1'b1;
                    end else if (deep_stop_select) begin
                        state_nxt = `PMC_ST_WATCH;
                    end else begin
                        state_nxt = `PMC_ST_SUBSLEEP;
                    end
                end
            end
            `PMC_ST_SUBSLEEP: begin
                if (wake_ok) begin
                    state_nxt = `PMC_ST_SUBACT;
                    exc_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt = `PMC_ST_ACT_HI;
            end
        endcase
    end

    // Reset pin forces active high speed from any mode, sleep included
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= `PMC_ST_ACT_HI;
            wait_med_r <= 1'b0;
            pend_direct_r <= 1'b0;
            exc_start <= 1'b0;
            exc_direct <= 1'b0;
            cpu_reset <= 1'b1;
        end else if (!external_reset_pin_n) begin
            state_r <= `PMC_ST_ACT_HI;
            wait_med_r <= 1'b0;
            pend_direct_r <= 1'b0;
            exc_start <= 1'b0;
            exc_direct <= 1'b0;
            cpu_reset <= 1'b1;
        end else begin
            state_r <= state_nxt;
            wait_med_r <= wait_med_nxt;
            pend_direct_r <= pend_direct_nxt;
            exc_start <= exc_nxt;
            exc_direct <= exc_dir_nxt;
            cpu_reset <= 1'b0;
        end
    end

    assign mode = state_r;
    assign cpu_run = (state_r == `PMC_ST_ACT_HI) || (state_r == `PMC_ST_ACT_MED) ||
        (state_r == `PMC_ST_SUBACT);
    assign cpu_halt = !cpu_run;
    // Gating follows the mode actually entered, so a pin reset also restores the clocks
    assign mode_nxt = external_reset_pin_n ? state_nxt : `PMC_ST_ACT_HI;

    // Clock gating and pin controls registered from the next mode
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            main_osc_en <= 1'b1;
            sub_osc_en <= 1'b1;
            periph_clk_en <= 1'b1;
            periph_div <= 2'h0;
            timekeep_clk_en <= 1'b1;
            adc_pwm_clk_en <= 1'b1;
            ports_hiz <= 1'b0;
            ports_hold <= 1'b0;
            cpu_on_subclock <= 1'b0;
            cpu_sub_div <= 4'h2;
        end else begin
            sub_osc_en <= 1'b1;
            // Main clock restarts as soon as the settling wait begins
            main_osc_en <= !((mode_nxt == `PMC_ST_STANDBY) || (mode_nxt == `PMC_ST_WATCH) ||
                (mode_nxt == `PMC_ST_SUBACT) || (mode_nxt == `PMC_ST_SUBSLEEP));
            periph_clk_en <= (mode_nxt == `PMC_ST_ACT_HI) || (mode_nxt == `PMC_ST_ACT_MED) ||
                (mode_nxt == `PMC_ST_SLEEP_HI) || (mode_nxt == `PMC_ST_SLEEP_MED) ||
                (mode_nxt == `PMC_ST_SUBACT) || (mode_nxt == `PMC_ST_SUBSLEEP);
            periph_div <= ((mode_nxt == `PMC_ST_ACT_MED) || (mode_nxt == `PMC_ST_SLEEP_MED)) ?
                {periph_div_sel_hi, periph_div_sel_lo} : 2'h0;
            timekeep_clk_en <= (mode_nxt != `PMC_ST_STANDBY) &&
                (mode_nxt != `PMC_ST_WAKE_WAIT);
            adc_pwm_clk_en <= (mode_nxt == `PMC_ST_ACT_HI) || (mode_nxt == `PMC_ST_ACT_MED) ||
                (mode_nxt == `PMC_ST_SLEEP_HI) || (mode_nxt == `PMC_ST_SLEEP_MED);
            ports_hiz <= (mode_nxt == `PMC_ST_STANDBY);
            ports_hold <= (mode_nxt == `PMC_ST_WATCH) ||
                (mode_nxt == `PMC_ST_SUBSLEEP);
            cpu_on_subclock <= (mode_nxt == `PMC_ST_SUBACT);
            case ({subactive_freq_hi, subactive_freq_lo})
                `PMC_SA_DIV2: cpu_sub_div <= 4'h2;
                `PMC_SA_DIV4: cpu_sub_div <= 4'h4;
                default: cpu_sub_div <= 4'h8;
            endcase
        end
    end
endmodule

// ---- test/pmc_ctrl_properties.sv ----
// Port checker for the power mode sequencer
`timescale 1ns/10ps
module pmc_ctrl_checker (
    input wire clk,
    input wire sys_rst,
    input wire external_reset_pin_n,
    input wire sleep_exec,
    input wire irq_pending,
    input wire irq_enabled,
    input wire int_mask,
    input wire direct_irq_enable,
    input wire deep_stop_select,
    input wire low_speed_select,
    input wire medium_speed_select,
    input wire direct_switch_enable,
    input wire subactive_freq_hi,
    input wire subactive_freq_lo,
    input wire cpu_reset,
    input wire cpu_halt,
    input wire cpu_run,
    input wire main_osc_en,
    input wire sub_osc_en,
    input wire periph_clk_en,
    input wire timekeep_clk_en,
    input wire adc_pwm_clk_en,
    input wire ports_hiz,
    input wire ports_hold,
    input wire cpu_on_subclock,
    input wire [3:0] cpu_sub_div,
    input wire exc_start,
    input wire exc_direct,
    input wire [8:0] mode
);
    wire wk = irq_pending && irq_enabled && !int_mask && external_reset_pin_n;
    wire hush = (int_mask || !irq_enabled) && external_reset_pin_n;
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    a_sleep_gating: assert property (
        mode == 9'h004 |-> cpu_halt && main_osc_en && sub_osc_en && periph_clk_en)
        else $error("sleep gating wrong");
    a_masked_sleep_holds: assert property ((mode == 9'h004 && hush) [*3] |=> mode == 9'h004)
        else $error("masked interrupt left sleep");
    a_sleep_hi_wake: assert property (
        mode == 9'h004 && wk |-> ##[1:2] (exc_start && mode == 9'h001))
        else $error("high speed sleep wake wrong");
    a_sleep_med_wake: assert property (
        mode == 9'h008 && wk |-> ##[1:2] (exc_start && mode == 9'h002))
        else $error("medium speed sleep wake wrong");
    a_pin_reset: assert property (!external_reset_pin_n |=> mode == 9'h001 && cpu_reset)
        else $error("pin reset not taken");
    a_standby_gating: assert property (
        mode == 9'h010 |-> !main_osc_en && ports_hiz && cpu_halt && !periph_clk_en)
        else $error("standby gating wrong");
    a_watch_gating: assert property (
        mode == 9'h020 |-> ports_hold && timekeep_clk_en && !periph_clk_en && !main_osc_en)
        else $error("watch gating wrong");
    a_subact_clock: assert property (
        mode == 9'h040 && $stable({subactive_freq_hi, subactive_freq_lo})
        |-> !main_osc_en && cpu_run && cpu_on_subclock && !adc_pwm_clk_en
        && cpu_sub_div == (subactive_freq_hi ? 4'h8 : subactive_freq_lo ? 4'h4 : 4'h2))
        else $error("subactive clocking wrong");
    a_subsleep_wake: assert property (
        mode == 9'h080 && wk |-> ##[1:2] (exc_start && mode == 9'h040))
        else $error("subsleep wake wrong");
    a_direct_via_sleep: assert property (
        (mode == 9'h001 || mode == 9'h002) && sleep_exec
        && direct_switch_enable && direct_irq_enable && !deep_stop_select && !low_speed_select
        |-> ##2 (exc_start && exc_direct
        && mode == ($past(medium_speed_select, 2) ? 9'h002 : 9'h001)))
        else $error("direct speed switch wrong");
endmodule

// ---- test/pmc_cpu_model.sv ----
// CPU and interrupt side model: issues SLEEP pulses and holds requests
`timescale 1ns/10ps
module pmc_cpu_model (
    input wire clk,
    input wire sys_rst,
    input wire sleep_req,
    input wire irq_req,
    input wire exc_start,
    output reg sleep_exec,
    output reg irq_pending
);
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sleep_exec <= 1'h0;
            irq_pending <= 1'h0;
        end else begin
            sleep_exec <= sleep_req && !sleep_exec;
            // Request stays up until taken, a dropped request would be lost
            if (exc_start)
                irq_pending <= 1'h0;
            else if (irq_req)
                irq_pending <= 1'h1;
        end
    end
endmodule

// ---- test/tb_power_mode_controller.sv ----
// Testbench for the power mode sequencer
`timescale 1ns/10ps
module tb_power_mode_controller;
    logic clk, sys_rst, external_reset_pin_n, sleep_exec, irq_pending, irq_enabled, int_mask;
    logic direct_irq_enable, deep_stop_select, low_speed_select, watch_timer_select;
    logic medium_speed_select, direct_switch_enable, periph_div_sel_hi, periph_div_sel_lo;
    logic subactive_freq_hi, subactive_freq_lo, wake_wait_sel_2, wake_wait_sel_1, wake_wait_sel_0;
    logic cpu_reset, cpu_halt, cpu_run, main_osc_en, sub_osc_en, periph_clk_en, timekeep_clk_en;
    logic adc_pwm_clk_en, ports_hiz, ports_hold, cpu_on_subclock, exc_start, exc_direct;
    logic sleep_req, irq_req;
    logic [1:0] periph_div;
    logic [3:0] cpu_sub_div;
    logic [8:0] mode;
    int fails = 0;
    int compares = 0;
    pmc_ctrl u_dut (.*);
    pmc_cpu_model u_cpu (.clk(clk), .sys_rst(sys_rst), .sleep_req(sleep_req), .irq_req(irq_req),
        .exc_start(exc_start), .sleep_exec(sleep_exec), .irq_pending(irq_pending));
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    // Bits are {deep stop, watch timer, low speed, medium speed, direct switch}
    task automatic slp(input logic [4:0] b);
        @(posedge clk);
        {deep_stop_select, watch_timer_select, low_speed_select, medium_speed_select,
            direct_switch_enable} <= b;
        sleep_req <= 1'h1;
        @(posedge clk);
        sleep_req <= 1'h0;
    endtask
    task automatic irq;
        @(posedge clk);
        irq_req <= 1'h1;
        @(posedge clk);
        irq_req <= 1'h0;
    endtask
    task automatic wexc(input int n, input logic [8:0] m, input logic d);
        for (int i = 0; i < n && exc_start !== 1'h1; i++)
            @(negedge clk);
        chk("exc_start", 9'h001, 9'(exc_start));
        chk("mode", m, mode);
        chk("exc_direct", 9'(d), 9'(exc_direct));
    endtask
    task automatic t_sleep;
        slp(5'b00000);
        step(2);
        chk("sleep mode", 9'h004, mode);
        chk("cpu halt", 9'h001, 9'(cpu_halt));
        @(posedge clk);
        int_mask <= 1'h1;
        irq();
        step(8);
        chk("masked sleep", 9'h004, mode);
        @(posedge clk);
        int_mask <= 1'h0;
        irq_enabled <= 1'h0;
        step(8);
        chk("disabled sleep", 9'h004, mode);
        @(posedge clk);
        irq_enabled <= 1'h1;
        wexc(3, 9'h001, 1'h0);
        $display("t_sleep done");
    endtask
    task automatic t_speed;
        slp(5'b00011);
        wexc(6, 9'h002, 1'h1);
        slp(5'b00000);
        step(2);
        chk("medium sleep", 9'h008, mode);
        chk("periph div", 9'h002, 9'(periph_div));
        irq();
        wexc(3, 9'h002, 1'h0);
        slp(5'b00001);
        wexc(6, 9'h001, 1'h1);
        @(posedge clk);
        direct_irq_enable <= 1'h0;
        slp(5'b00001);
        step(2);
        chk("direct refused", 9'h004, mode);
        @(posedge clk);
        direct_irq_enable <= 1'h1;
        irq();
        wexc(3, 9'h001, 1'h0);
        $display("t_speed done");
    endtask
    task automatic t_standby;
        slp(5'b11010);
        step(2);
        chk("standby", 9'h010, mode);
        chk("ports hiz", 9'h001, 9'(ports_hiz));
        irq();
        step(10);
        chk("settling", 9'h100, mode);
        wexc(30, 9'h002, 1'h0);
        slp(5'b00001);
        wexc(6, 9'h001, 1'h1);
        $display("t_standby done");
    endtask
    task automatic t_watch;
        slp(5'b10100);
        step(2);
        chk("watch", 9'h020, mode);
        chk("ports hold", 9'h001, 9'(ports_hold));
        irq();
        wexc(3, 9'h040, 1'h0);
        slp(5'b00100);
        step(2);
        chk("subsleep", 9'h080, mode);
        irq();
        wexc(3, 9'h040, 1'h0);
        slp(5'b10000);
        step(2);
        chk("watch from sub", 9'h020, mode);
        irq();
        wexc(40, 9'h001, 1'h0);
        $display("t_watch done");
    endtask
    task automatic t_sub;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            {subactive_freq_hi, subactive_freq_lo} <= 2'(i);
            slp(5'b11101);
            wexc(10, 9'h040, 1'h1);
            chk("sub divider", 9'(4'h2 << i), 9'(cpu_sub_div));
            slp(5'b11001);
            wexc(40, 9'h001, 1'h1);
        end
        $display("t_sub done");
    endtask
    task automatic t_pin;
        slp(5'b00000);
        step(2);
        @(posedge clk);
        external_reset_pin_n <= 1'h0;
        step(4);
        chk("pin reset mode", 9'h001, mode);
        chk("cpu reset", 9'h001, 9'(cpu_reset));
        // Pin held low for five clocks before release
        @(posedge clk);
        external_reset_pin_n <= 1'h1;
        step(3);
        chk("cpu reset off", 9'h000, 9'(cpu_reset));
        $display("t_pin done");
    endtask
    task print_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        print_verdict();
    end
    initial begin
        {sys_rst, external_reset_pin_n, irq_enabled, direct_irq_enable} = 4'hf;
        {int_mask, deep_stop_select, low_speed_select, watch_timer_select} = 4'h0;
        {medium_speed_select, direct_switch_enable, subactive_freq_hi, subactive_freq_lo} = 4'h0;
        {periph_div_sel_hi, periph_div_sel_lo, sleep_req, irq_req} = 4'h8;
        // Shortest settling select keeps the run brief
        {wake_wait_sel_2, wake_wait_sel_1, wake_wait_sel_0} = 3'h7;
        repeat (6) @(posedge clk);
        sys_rst <= 1'h0;
        t_sleep();
        t_speed();
        t_standby();
        t_watch();
        t_sub();
        t_pin();
        print_verdict();
    end
endmodule
bind pmc_ctrl pmc_ctrl_checker u_chk (.*);
